// *** hdl/switch_monitor_pkg.sv ***
package switch_monitor_pkg;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS         = 40;
  localparam int RESET_MIN_NS          = 2000;
  localparam int RESET_MIN_CYCLES      =
    (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_PEND_US         = 1;
  localparam int RESET_PEND_CYCLES_DEF =
    (RESET_PEND_US * 1000000) / (CLK_PERIOD_NS * 1000) * 1000;
  localparam int INIT_CYCLES           = 16;
  localparam int CNT_W                 = 16;
  localparam int HI_CNT_W              = 6;

  // ==========================================================
  // register map, byte addresses of 32-bit words
  localparam logic [7:0] ADDR_CONFIG    = 8'h00;
  localparam logic [7:0] ADDR_INPUT_CFG = 8'h04;
  localparam logic [7:0] ADDR_CLEAN     = 8'h08;
  localparam logic [7:0] ADDR_EVENT     = 8'h0c;
  localparam logic [7:0] ADDR_MISC      = 8'h10;
  localparam logic [7:0] ADDR_CRC       = 8'h14;

  // config register fields
  localparam int CFG_RUN_BIT   = 0;
  localparam int CFG_CRC_BIT   = 1;
  localparam int CFG_SWRST_BIT = 2;
  localparam int CFG_FIELD_LSB = 8;
  localparam int CFG_FIELD_W   = 8;
  localparam int INPUT_CFG_W   = 24;
  localparam int CLEAN_W       = 8;
  localparam int CRC_W         = 8;
  localparam logic [CRC_W-1:0] CRC_POLY = 8'h07;

  // values after reset
  localparam logic [CFG_FIELD_W-1:0] CFG_FIELD_RST = 8'h00;
  localparam logic [INPUT_CFG_W-1:0] INPUT_CFG_RST = 24'h000000;
  localparam logic [CLEAN_W-1:0]     CLEAN_RST     = 8'h00;

  // ==========================================================
  // types
  typedef enum logic [2:0] {
    ST_INIT  = 3'b000,
    ST_IDLE  = 3'b001,
    ST_RUN   = 3'b010,
    ST_UV    = 3'b011,
    ST_PEND  = 3'b100,
    ST_RESET = 3'b101
  } sup_state_e;

  typedef struct packed {
    logic switch_change_event;
    logic undervoltage_event_bit;
    logic selfcheck_error_flag;
    logic power_on;
  } evt_s;

  typedef struct packed {
    logic cs_n;
    logic vdd_ok;
    logic uv_det;
    logic rst_pin;
  } pins_s;

  localparam int PINS_W = 4;
  // sampler idle levels: chip select high, supply present
  localparam logic [PINS_W-1:0] PINS_RST = 4'hc;

endpackage

// *** hdl/pin_sync.sv ***
`timescale 1ns/10ps
// three-stage sampler: output follows once stages two and three agree
module pin_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             rst_n_i,
  // pins
  input  wire logic [WIDTH-1:0] d_i,
  input  wire logic [WIDTH-1:0] rst_val_i,
  output      logic [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;
  logic [WIDTH-1:0] q_nxt;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_comb begin
        q_nxt[g] = (s2_r[g] == s3_r[g]) ? s3_r[g] : q_o[g];
      end
    end
  endgenerate

  // reset to the idle level of each pin so no false edge follows reset
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      s1_r <= rst_val_i;
      s2_r <= rst_val_i;
      s3_r <= rst_val_i;
      q_o  <= rst_val_i;
    end else begin
      s1_r <= d_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_o  <= q_nxt;
    end
  end

endmodule

// *** hdl/switch_monitor_supervisor.sv ***
// Chosen here: the address map and the Wishbone interface to the registers.
`timescale 1ns/10ps
module switch_monitor_supervisor
  import switch_monitor_pkg::*;
#(
  parameter int RESET_PEND_CYCLES = RESET_PEND_CYCLES_DEF
) (
  // clock and reset
  input  wire logic                   ref_clk_i,
  input  wire logic                   rst_n_i,
  // wishbone slave
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [7:0]             wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output      logic [31:0]            wb_dat_o,
  output      logic                   wb_ack_o,
  // pins and supply detectors
  input  wire logic                   reset_pin_i,
  input  wire logic                   uv_det_i,
  input  wire logic                   vdd_ok_i,
  input  wire logic                   cs_n_i,
  // polling engine and factory trim
  input  wire logic                   selfcheck_ok_i,
  input  wire logic                   poll_cycle_done_i,
  // interrupt and serial status
  output      logic                   int_n_o,
  output      logic                   por_flag_o,
  output      logic                   other_int_serial_flag_o,
  output      logic                   serial_en_o,
  // monitoring control
  output      logic                   wetting_en_o,
  output      logic                   monitor_en_o,
  output      logic                   poll_restart_o,
  output      logic                   baseline_load_o,
  output      logic [CFG_FIELD_W-1:0] cfg_field_o,
  output      logic [INPUT_CFG_W-1:0] input_cfg_o,
  output      logic [CLEAN_W-1:0]     clean_current_o
);

  // ==========================================================
  // functions
  function automatic logic [7:0] lane_merge(input logic [7:0] old_v,
                                            input logic [7:0] new_v,
                                            input logic       en);
    lane_merge = en ? new_v : old_v;
  endfunction

  function automatic logic [CRC_W-1:0] crc_calc(input logic [47:0] d);
    logic [CRC_W-1:0] c;
    c = '0;
    for (int i = 47; i >= 0; i--) begin
      if (c[CRC_W-1] ^ d[i]) begin
        c = {c[CRC_W-2:0], 1'b0} ^ CRC_POLY;
      end else begin
        c = {c[CRC_W-2:0], 1'b0};
      end
    end
    crc_calc = c;
  endfunction

  // ==========================================================
  // input synchronization
  pins_s pins_raw;
  pins_s pins_s_q;

  assign pins_raw = '{cs_n: cs_n_i, vdd_ok: vdd_ok_i,
                      uv_det: uv_det_i, rst_pin: reset_pin_i};

  pin_sync #(
    .WIDTH     (PINS_W)
  ) u_pin_sync (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .d_i       (pins_raw),
    .rst_val_i (PINS_RST),
    .q_o       (pins_s_q)
  );

  // ==========================================================
  // state
  sup_state_e             state_r,     state_nxt;
  logic [CNT_W-1:0]       cnt_r,       cnt_nxt;
  logic [HI_CNT_W-1:0]    hi_cnt_r,    hi_cnt_nxt;
  evt_s                   evt_r,       evt_nxt;
  logic                   uv_live_r,   uv_live_nxt;
  logic                   first_r,     first_nxt;
  logic                   evt_read_r,  evt_read_nxt;
  logic                   cs_prev_r,   cs_prev_nxt;
  logic                   run_r,       run_nxt;
  logic [CFG_FIELD_W-1:0] cfg_r,       cfg_nxt;
  logic [INPUT_CFG_W-1:0] incfg_r,     incfg_nxt;
  logic [CLEAN_W-1:0]     clean_r,     clean_nxt;
  logic [CRC_W-1:0]       crc_r,       crc_nxt;
  logic                   ack_nxt;
  logic [31:0]            dat_nxt;
  logic                   int_n_nxt;
  logic                   wet_nxt;
  logic                   restart_nxt;
  logic                   base_nxt;
  logic                   ser_nxt;

  evt_s                   evt_set;
  logic                   evt_clr;
  logic                   wb_req;
  logic                   wb_wr;
  logic                   cs_rise;
  logic                   pin_reset;
  logic                   held;
  logic                   swrst;

  // ==========================================================
  // next-state logic
  always_comb begin
    state_nxt    = state_r;
    cnt_nxt      = cnt_r;
    hi_cnt_nxt   = hi_cnt_r;
    uv_live_nxt  = uv_live_r;
    first_nxt    = first_r;
    evt_read_nxt = evt_read_r;
    cs_prev_nxt  = pins_s_q.cs_n;
    run_nxt      = run_r;
    cfg_nxt      = cfg_r;
    incfg_nxt    = incfg_r;
    clean_nxt    = clean_r;
    crc_nxt      = crc_r;
    restart_nxt  = 1'b0;
    base_nxt     = 1'b0;
    swrst        = 1'b0;
    evt_set      = '0;
    evt_clr      = 1'b0;
    dat_nxt      = 32'h00000000;

    held    = (state_r == ST_RESET) || (state_r == ST_PEND) ||
              (state_r == ST_INIT);
    wb_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wb_wr   = wb_req && wb_we_i && !held;
    ack_nxt = wb_req;
    cs_rise = pins_s_q.cs_n && !cs_prev_r;

    // reset pin must stay high the full minimum before it counts
    if (pins_s_q.rst_pin) begin
      if (hi_cnt_r != HI_CNT_W'(RESET_MIN_CYCLES - 1)) begin
        hi_cnt_nxt = hi_cnt_r + HI_CNT_W'(1);
      end
    end else begin
      hi_cnt_nxt = '0;
    end
    pin_reset = pins_s_q.rst_pin &&
                (hi_cnt_r == HI_CNT_W'(RESET_MIN_CYCLES - 1));

    // register reads
    if (wb_req && !wb_we_i && !held) begin
      if (wb_adr_i == ADDR_CONFIG) begin
        dat_nxt[CFG_RUN_BIT] = run_r;
        dat_nxt[CFG_FIELD_LSB +: CFG_FIELD_W] = cfg_r;
      end else if (wb_adr_i == ADDR_INPUT_CFG) begin
        dat_nxt[INPUT_CFG_W-1:0] = incfg_r;
      end else if (wb_adr_i == ADDR_CLEAN) begin
        dat_nxt[CLEAN_W-1:0] = clean_r;
      end else if (wb_adr_i == ADDR_EVENT) begin
        dat_nxt[3:0] = evt_r;
        if (!pins_s_q.cs_n) begin
          evt_read_nxt = 1'b1;
        end
      end else if (wb_adr_i == ADDR_MISC) begin
        dat_nxt[0]   = uv_live_r;
        dat_nxt[6:4] = state_r;
      end else if (wb_adr_i == ADDR_CRC) begin
        dat_nxt[CRC_W-1:0] = crc_r;
      end
    end

    // register writes; the lock follows the run bit
    if (wb_wr) begin
      if (wb_adr_i == ADDR_CONFIG) begin
        if (wb_sel_i[0]) begin
          run_nxt = wb_dat_i[CFG_RUN_BIT];
          swrst   = wb_dat_i[CFG_SWRST_BIT];
          if (wb_dat_i[CFG_CRC_BIT]) begin
            crc_nxt = crc_calc({8'h00, incfg_r, clean_r, cfg_r});
          end
        end
        if (!run_r) begin
          cfg_nxt = lane_merge(cfg_r, wb_dat_i[15:8],
                               wb_sel_i[1]);
        end
      end else if (wb_adr_i == ADDR_INPUT_CFG) begin
        if (!run_r) begin
          for (int b = 0; b < 3; b++) begin
            incfg_nxt[b*8 +: 8] = lane_merge(incfg_r[b*8 +: 8],
                                             wb_dat_i[b*8 +: 8],
                                             wb_sel_i[b]);
          end
        end
      end else if (wb_adr_i == ADDR_CLEAN) begin
        clean_nxt = lane_merge(clean_r, wb_dat_i[7:0],
                               wb_sel_i[0]);
      end
    end

    // event register clear at chip-select rise after a read
    if (cs_rise) begin
      evt_read_nxt = 1'b0;
      evt_clr      = evt_read_r;
    end

    // supervisory sequence
    case (state_r)
      ST_INIT: begin
        cnt_nxt = cnt_r + CNT_W'(1);
        if (cnt_r == CNT_W'(INIT_CYCLES - 1)) begin
          cnt_nxt                      = '0;
          evt_set.power_on             = 1'b1;
          evt_set.selfcheck_error_flag = !selfcheck_ok_i;
          state_nxt                    = ST_IDLE;
        end
      end
      ST_IDLE, ST_RUN: begin
        if (pins_s_q.uv_det) begin
          evt_set.undervoltage_event_bit = 1'b1;
          uv_live_nxt = 1'b1;
          first_nxt   = 1'b0;
          state_nxt   = ST_UV;
        end else if (run_nxt) begin
          state_nxt = ST_RUN;
        end else begin
          state_nxt = ST_IDLE;
          first_nxt = 1'b0;
        end
        if (state_r == ST_RUN && first_r && poll_cycle_done_i) begin
          evt_set.switch_change_event = 1'b1;
          base_nxt  = 1'b1;
          first_nxt = 1'b0;
        end
      end
      ST_UV: begin
        // only the two edges of the condition raise events
        if (!pins_s_q.uv_det) begin
          evt_set.undervoltage_event_bit = 1'b1;
          uv_live_nxt = 1'b0;
          if (run_nxt) begin
            state_nxt   = ST_RUN;
            restart_nxt = 1'b1;
            first_nxt   = 1'b1;
          end else begin
            state_nxt = ST_IDLE;
          end
        end
      end
      ST_PEND: begin
        // finishing with a pending interrupt takes the long wait
        cnt_nxt = cnt_r + CNT_W'(1);
        if (cnt_r == CNT_W'(RESET_PEND_CYCLES - 1)) begin
          cnt_nxt   = '0;
          state_nxt = ST_RESET;
        end
      end
      ST_RESET: begin
        if (!pins_s_q.rst_pin) begin
          cnt_nxt   = '0;
          state_nxt = ST_INIT;
        end
      end
      default: begin
        state_nxt = ST_INIT;
      end
    endcase

    evt_nxt = evt_s'((evt_clr ? 4'h0 : evt_r) | evt_set);

    // reset paths override the sequence and clear the settings; events are kept in the pending wait
    if (pin_reset && state_r != ST_PEND && state_r != ST_RESET) begin
      state_nxt = (evt_r != 4'h0) ? ST_PEND : ST_RESET;
      cnt_nxt   = '0;
    end else if (swrst) begin
      state_nxt = ST_INIT;
      cnt_nxt   = '0;
    end
    if (state_nxt == ST_RESET || state_nxt == ST_PEND ||
        (state_nxt == ST_INIT && state_r != ST_INIT)) begin
      run_nxt      = 1'b0;
      cfg_nxt      = CFG_FIELD_RST;
      incfg_nxt    = INPUT_CFG_RST;
      clean_nxt    = CLEAN_RST;
      crc_nxt      = '0;
      uv_live_nxt  = 1'b0;
      first_nxt    = 1'b0;
      evt_read_nxt = 1'b0;
      restart_nxt  = 1'b0;
      base_nxt     = 1'b0;
      if (state_nxt != ST_PEND) begin
        evt_nxt = '0;
      end
    end

    int_n_nxt = (evt_nxt == 4'h0);
    wet_nxt   = (state_nxt == ST_RUN);
    // serial path follows the logic supply; settings stay untouched
    ser_nxt   = pins_s_q.vdd_ok && (state_nxt != ST_RESET) &&
                (state_nxt != ST_PEND);
  end

  // ==========================================================
  // registers
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      state_r                 <= ST_INIT;
      cnt_r                   <= '0;
      hi_cnt_r                <= '0;
      evt_r                   <= '0;
      uv_live_r               <= 1'b0;
      first_r                 <= 1'b0;
      evt_read_r              <= 1'b0;
      cs_prev_r               <= 1'b1;
      run_r                   <= 1'b0;
      cfg_r                   <= CFG_FIELD_RST;
      incfg_r                 <= INPUT_CFG_RST;
      clean_r                 <= CLEAN_RST;
      crc_r                   <= '0;
      wb_ack_o                <= 1'b0;
      wb_dat_o                <= 32'h00000000;
      int_n_o                 <= 1'b1;
      por_flag_o              <= 1'b0;
      other_int_serial_flag_o <= 1'b0;
      serial_en_o             <= 1'b0;
      wetting_en_o            <= 1'b0;
      monitor_en_o            <= 1'b0;
      poll_restart_o          <= 1'b0;
      baseline_load_o         <= 1'b0;
    end else begin
      state_r                 <= state_nxt;
      cnt_r                   <= cnt_nxt;
      hi_cnt_r                <= hi_cnt_nxt;
      evt_r                   <= evt_nxt;
      uv_live_r               <= uv_live_nxt;
      first_r                 <= first_nxt;
      evt_read_r              <= evt_read_nxt;
      cs_prev_r               <= cs_prev_nxt;
      run_r                   <= run_nxt;
      cfg_r                   <= cfg_nxt;
      incfg_r                 <= incfg_nxt;
      clean_r                 <= clean_nxt;
      crc_r                   <= crc_nxt;
      wb_ack_o                <= ack_nxt;
      wb_dat_o                <= dat_nxt;
      int_n_o                 <= int_n_nxt;
      por_flag_o              <= evt_nxt.power_on;
      other_int_serial_flag_o <= evt_nxt.undervoltage_event_bit ||
                                 uv_live_nxt;
      serial_en_o             <= ser_nxt;
      wetting_en_o            <= wet_nxt;
      monitor_en_o            <= wet_nxt;
      poll_restart_o          <= restart_nxt;
      baseline_load_o         <= base_nxt;
    end
  end

  // ==========================================================
  // outputs of stored configuration
  assign cfg_field_o     = cfg_r;
  assign input_cfg_o     = incfg_r;
  assign clean_current_o = clean_r;

endmodule

// *** tb/supervisor_monitor.sv ***
`timescale 1ns/10ps
module supervisor_monitor
  import switch_monitor_pkg::*;
#(
  parameter int RESET_PEND_CYCLES = 20
) (
  // clock, reset, bus
  input wire logic                   ref_clk_i,
  input wire logic                   rst_n_i,
  input wire logic                   wb_cyc_i,
  input wire logic                   wb_stb_i,
  input wire logic                   wb_we_i,
  input wire logic [7:0]             wb_adr_i,
  input wire logic [31:0]            wb_dat_o,
  input wire logic                   wb_ack_o,
  // pins
  input wire logic                   reset_pin_i,
  input wire logic                   uv_det_i,
  input wire logic                   vdd_ok_i,
  input wire logic                   poll_cycle_done_i,
  // status and control
  input wire logic                   int_n_o,
  input wire logic                   other_int_serial_flag_o,
  input wire logic                   serial_en_o,
  input wire logic                   monitor_en_o,
  input wire logic                   poll_restart_o,
  input wire logic                   baseline_load_o,
  input wire logic [INPUT_CFG_W-1:0] input_cfg_o
);
  // ==========================================================
  // reset pin high time, saturating
  localparam int HOLD_LIM = 60 + RESET_PEND_CYCLES;
  logic [15:0] hi_cnt_r;
  logic [15:0] hi_cnt_nxt;
  always_comb begin
    hi_cnt_nxt = reset_pin_i ? hi_cnt_r + 16'h0001 : 16'h0000;
    if (hi_cnt_r == 16'hffff) begin
      hi_cnt_nxt = hi_cnt_r;
    end
  end
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      hi_cnt_r <= 16'h0000;
    end else begin
      hi_cnt_r <= hi_cnt_nxt;
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // ==========================================================
  // assertions
  ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus access not acknowledged next cycle");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  idle_data_zero_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside ack");
  init_wait_a: assert property (
    $rose(rst_n_i) |-> int_n_o [*8] ##[4:16] !int_n_o)
    else $error("interrupt after init out of window");
  uv_stop_a: assert property ($rose(uv_det_i) |-> ##[3:8] !monitor_en_o)
    else $error("monitoring not stopped on undervoltage");
  uv_flag_a: assert property (
    $rose(uv_det_i) && int_n_o |-> ##[3:8] other_int_serial_flag_o && !int_n_o)
    else $error("undervoltage entry not flagged");
  sync_delay_a: assert property (
    $rose(uv_det_i) && monitor_en_o |=> monitor_en_o)
    else $error("detector acted without synchronisation");
  uv_exit_int_a: assert property ($fell(uv_det_i) |-> ##[3:8] !int_n_o)
    else $error("no interrupt on undervoltage exit");
  restart_run_a: assert property (
    poll_restart_o |=> !poll_restart_o && monitor_en_o)
    else $error("poll restart without running");
  baseline_cause_a: assert property (
    baseline_load_o |-> $past(poll_cycle_done_i) || $past(poll_cycle_done_i, 2))
    else $error("baseline load without poll cycle");
  pin_reset_a: assert property (
    hi_cnt_r == HOLD_LIM[15:0] |-> !serial_en_o && !monitor_en_o
      && input_cfg_o == '0)
    else $error("reset pin did not clear and stop");
  short_pin_a: assert property (
    reset_pin_i && hi_cnt_r < 16'd40 |-> $stable(input_cfg_o))
    else $error("short reset pulse acted");
  vdd_serial_a: assert property (!vdd_ok_i [*6] |-> !serial_en_o)
    else $error("serial active without logic supply");
  locked_cfg_a: assert property (
    wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && monitor_en_o
      && wb_adr_i == ADDR_INPUT_CFG |-> ##1 $stable(input_cfg_o) ##1
      $stable(input_cfg_o))
    else $error("locked register changed");
  uv_c: cover property ($rose(uv_det_i) ##[1:8] !monitor_en_o);
  base_c: cover property (baseline_load_o);
  pin_c: cover property (hi_cnt_r == HOLD_LIM[15:0]);
endmodule
bind switch_monitor_supervisor supervisor_monitor #(
  .RESET_PEND_CYCLES(RESET_PEND_CYCLES)
) u_monitor (.ref_clk_i, .rst_n_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_dat_o, .wb_ack_o, .reset_pin_i, .uv_det_i, .vdd_ok_i,
  .poll_cycle_done_i, .int_n_o, .other_int_serial_flag_o, .serial_en_o,
  .monitor_en_o, .poll_restart_o, .baseline_load_o, .input_cfg_o);

// *** tb/controller_model.sv ***
`timescale 1ns/10ps
// controller side: chip select frames and the reset pin
module controller_model (
  // clock
  input  wire logic ref_clk_i,
  // pins
  output      logic cs_n_o,
  output      logic reset_pin_o
);
  initial begin
    cs_n_o = 1'b1;
    reset_pin_o = 1'b0;
  end
  // long enough for the three-flop sampler to see it
  task automatic frame(input logic sel);
    @(posedge ref_clk_i);
    cs_n_o <= !sel;
    repeat (6) @(posedge ref_clk_i);
  endtask
  // level held steady for the whole pulse
  task automatic pin_pulse(input int cycles);
    @(posedge ref_clk_i);
    reset_pin_o <= 1'b1;
    repeat (cycles) @(posedge ref_clk_i);
    reset_pin_o <= 1'b0;
  endtask
endmodule

// *** tb/switch_monitor_supervisor_bench.sv ***
`timescale 1ns/10ps
module switch_monitor_supervisor_bench;
  import switch_monitor_pkg::*;
  typedef struct packed {
    logic [31:0] e;
    logic [31:0] m;
  } note_s;
  logic ref_clk_i, rst_n_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, lfsr_r;
  logic reset_pin_i, uv_det_i, vdd_ok_i, cs_n_i, selfcheck_ok_i;
  logic poll_cycle_done_i, int_n_o, por_flag_o, other_int_serial_flag_o;
  logic serial_en_o, wetting_en_o, monitor_en_o, poll_restart_o;
  logic baseline_load_o;
  logic [CFG_FIELD_W-1:0] cfg_field_o;
  logic [INPUT_CFG_W-1:0] input_cfg_o, cfg_v;
  logic [CLEAN_W-1:0] clean_current_o;
  int miscompares, check_count, restarts, baselines;
  note_s notes[$];
  note_s nt;
  switch_monitor_supervisor #(.RESET_PEND_CYCLES(20)) dut (.ref_clk_i,
    .rst_n_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .reset_pin_i, .uv_det_i, .vdd_ok_i,
    .cs_n_i, .selfcheck_ok_i, .poll_cycle_done_i, .int_n_o, .por_flag_o,
    .other_int_serial_flag_o, .serial_en_o, .wetting_en_o, .monitor_en_o,
    .poll_restart_o, .baseline_load_o, .cfg_field_o, .input_cfg_o,
    .clean_current_o);
  controller_model ctrl (.ref_clk_i, .cs_n_o(cs_n_i),
    .reset_pin_o(reset_pin_i));
  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end
  function automatic logic [7:0] crc8(input logic [47:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 47; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? CRC_POLY : 8'h00);
    end
    return c;
  endfunction
  function automatic logic [31:0] lfsr_step(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic end_of_test();
    if (miscompares == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one classic cycle; the read expectation is queued for the watcher
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d, input logic [31:0] e,
                    input logic [31:0] m);
    int n;
    notes.push_back('{e, m});
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) chk(32'h1, 32'h0);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask
  task automatic wait_int(input logic lvl);
    int n;
    n = 0;
    while (int_n_o !== lvl && n < 200) begin
      @(posedge ref_clk_i);
      n++;
    end
    chk({31'h0, int_n_o}, {31'h0, lvl});
  endtask
  // event read inside a chip-select frame, then release
  task automatic clear_ev(input logic [31:0] e);
    ctrl.frame(1'b1);
    wb(1'b0, ADDR_EVENT, 32'h0, e, 32'hf);
    ctrl.frame(1'b0);
    wait_int(1'b1);
  endtask
  always @(posedge ref_clk_i) begin
    if (wb_ack_o === 1'b1) begin
      nt = notes.pop_front();
      chk(wb_dat_o & nt.m, nt.e & nt.m);
    end
    if (poll_restart_o === 1'b1) restarts++;
    if (baseline_load_o === 1'b1) baselines++;
  end
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    miscompares++;
    end_of_test();
  end
  initial begin
    {rst_n_i, wb_cyc_i, wb_stb_i, wb_we_i, uv_det_i} = 5'h0;
    {selfcheck_ok_i, poll_cycle_done_i, vdd_ok_i} = 3'h1;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h0;
    lfsr_r = 32'h00012783;
    repeat (12) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    wait_int(1'b0);
    chk({31'h0, por_flag_o}, 32'h1);
    wb(1'b0, ADDR_MISC, 32'h0, 32'h10, 32'h71);
    wb(1'b0, 8'h3c, 32'h0, 32'h0, 32'hffffffff);
    clear_ev(32'h3);
    selfcheck_ok_i <= 1'b1;
    wb(1'b1, ADDR_CONFIG, 32'h4, 32'h0, 32'h0);
    wait_int(1'b0);
    clear_ev(32'h1);
    lfsr_r = lfsr_step(lfsr_r);
    cfg_v = lfsr_r[23:0] | 24'h000001;
    wb(1'b1, ADDR_INPUT_CFG, {8'h0, cfg_v}, 32'h0, 32'h0);
    chk({31'h0, monitor_en_o}, 32'h0);
    wb(1'b1, ADDR_CONFIG, 32'h5a01, 32'h0, 32'h0);
    chk({30'h0, wetting_en_o, monitor_en_o}, 32'h3);
    wb(1'b1, ADDR_INPUT_CFG, {8'h0, ~cfg_v}, 32'h0, 32'h0);
    wb(1'b0, ADDR_INPUT_CFG, 32'h0, {8'h0, cfg_v}, 32'hffffff);
    wb(1'b1, ADDR_CONFIG, 32'ha503, 32'h0, 32'h0);
    chk({24'h0, cfg_field_o}, 32'h5a);
    chk({31'h0, monitor_en_o}, 32'h1);
    wb(1'b0, ADDR_CRC, 32'h0, {24'h0, crc8({8'h0, cfg_v, 16'h005a})},
       32'hff);
    wb(1'b1, ADDR_CLEAN, lfsr_r, 32'h0, 32'h0);
    wb(1'b0, ADDR_CLEAN, 32'h0, lfsr_r, 32'hff);
    chk({24'h0, clean_current_o}, {24'h0, lfsr_r[7:0]});
    wb(1'b1, ADDR_CONFIG, 32'h0, 32'h0, 32'h0);
    chk({31'h0, monitor_en_o}, 32'h0);
    cfg_v = ~cfg_v;
    wb(1'b1, ADDR_INPUT_CFG, {8'h0, cfg_v}, 32'h0, 32'h0);
    chk({8'h0, input_cfg_o}, {8'h0, cfg_v});
    wb(1'b1, ADDR_CONFIG, 32'h1, 32'h0, 32'h0);
    vdd_ok_i <= 1'b0;
    repeat (8) @(posedge ref_clk_i);
    chk({31'h0, serial_en_o}, 32'h0);
    chk({8'h0, input_cfg_o}, {8'h0, cfg_v});
    vdd_ok_i <= 1'b1;
    ctrl.pin_pulse(20);
    repeat (10) @(posedge ref_clk_i);
    chk({8'h0, input_cfg_o}, {8'h0, cfg_v});
    uv_det_i <= 1'b1;
    wait_int(1'b0);
    chk({28'h0, serial_en_o, wetting_en_o, monitor_en_o,
         other_int_serial_flag_o}, 32'h9);
    wb(1'b0, ADDR_MISC, 32'h0, 32'h31, 32'h71);
    wb(1'b0, ADDR_INPUT_CFG, 32'h0, {8'h0, cfg_v}, 32'hffffff);
    wb(1'b0, ADDR_EVENT, 32'h0, 32'h4, 32'hf);
    repeat (8) @(posedge ref_clk_i);
    chk({31'h0, int_n_o}, 32'h0);
    clear_ev(32'h4);
    repeat (30) @(posedge ref_clk_i);
    chk({31'h0, int_n_o}, 32'h1);
    uv_det_i <= 1'b0;
    wait_int(1'b0);
    wb(1'b0, ADDR_MISC, 32'h0, 32'h20, 32'h71);
    chk({restarts[30:0], monitor_en_o}, 32'h3);
    poll_cycle_done_i <= 1'b1;
    @(posedge ref_clk_i);
    poll_cycle_done_i <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    chk(baselines, 32'h1);
    wb(1'b0, ADDR_EVENT, 32'h0, 32'hc, 32'hf);
    ctrl.pin_pulse(100);
    wait_int(1'b0);
    chk({8'h0, input_cfg_o}, 32'h0);
    clear_ev(32'h1);
    end_of_test();
  end
endmodule
